// File: image_packer.sv
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// RULE_01: selected status bytes lead the image as general, input status, output status, test output.
// RULE_02: unselected status items take no byte and later items close up.
// RULE_03: on the newer unit, selected input monitor bytes then the output monitor byte follow status.
// RULE_04: no monitor space without selection, and the older unit never emits monitor bytes.
// RULE_05: registered tags follow in registration order, packed with no gaps.
// RULE_06: general status bit 0 is set while the input supply is faulty or absent.
// RULE_07: general status bit 1 is set while the output supply is faulty or absent.
// RULE_08: general status bit 2 is set when any standard connection reports an error.
// RULE_09: general status bit 3 is set only while all standard connections run normally.
// RULE_10: general status bit 4 is set when any safety connection reports an error.
// RULE_11: general status bit 5 is set only while all safety connections run normally.
// RULE_12: general status bit 6 is set only in run mode.
// RULE_13: general status bit 7 is the health flag, cleared while any error is present.
// RULE_14: the older unit sends input status as one two-byte word, terminals 0-7 then 8-15.
// RULE_15: the newer unit's input status byte 1 holds terminals 0-7, one means normal.
// RULE_16: the newer unit's input status byte 2 holds terminals 8-15, one means normal.
// RULE_17: word and double-word tags take consecutive bytes from the next free byte, unpadded.
module image_packer
(
  input  wire logic                                     aclk,
  input  wire logic                                     aresetn,
  input  wire logic [7:0]                               s_awaddr,
  input  wire logic                                     s_awvalid,
  output logic                                          s_awready,
  input  wire logic [31:0]                              s_wdata,
  input  wire logic [3:0]                               s_wstrb,
  input  wire logic                                     s_wvalid,
  output logic                                          s_wready,
  output logic [1:0]                                    s_bresp,
  output logic                                          s_bvalid,
  input  wire logic                                     s_bready,
  input  wire logic [7:0]                               s_araddr,
  input  wire logic                                     s_arvalid,
  output logic                                          s_arready,
  output logic [31:0]                                   s_rdata,
  output logic [1:0]                                    s_rresp,
  output logic                                          s_rvalid,
  input  wire logic                                     s_rready,
  input  wire image_packer_pkg::unit_status_t           unit_status,
  output logic [image_packer_pkg::IMG_BYTES*8-1:0]      image_data,
  output logic [image_packer_pkg::LEN_W-1:0]            image_len,
  output logic                                          irq
);

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [31:0]                            ctrl_reg;
  logic [31:0]                            select_reg;
  logic [31:0]                            tag_cnt_reg;
  logic [31:0]                            tag_size_reg;
  logic [31:0]                            irq_mask_reg;
  logic [image_packer_pkg::IRQ_W-1:0]     irq_stat_reg;
  logic [31:0]                            tag_data_reg [image_packer_pkg::TAG_N];
  logic [image_packer_pkg::IMG_BYTES*8-1:0] image_reg;
  logic [image_packer_pkg::LEN_W-1:0]     len_reg;
  logic                                   health_reg;
  logic                                   mode_reg;
  logic                                   irq_reg;
  logic                                   aw_held_reg;
  logic [7:0]                             awaddr_reg;
  logic                                   w_held_reg;
  logic [31:0]                            wdata_reg;
  logic [3:0]                             wstrb_reg;
  logic                                   awready_reg;
  logic                                   wready_reg;
  logic                                   bvalid_reg;
  logic [1:0]                             bresp_reg;
  logic                                   arready_reg;
  logic                                   rvalid_reg;
  logic [31:0]                            rdata_reg;
  logic [1:0]                             rresp_reg;

  // ----------------------------------------------------------------------------
  // general status byte
  // ----------------------------------------------------------------------------
  wire logic [7:0] gen_stat;
  // RULE_06 input supply flag
  assign gen_stat[image_packer_pkg::GS_IN_SUPPLY]  = unit_status.in_supply_fault;
  // RULE_07 output supply flag
  assign gen_stat[image_packer_pkg::GS_OUT_SUPPLY] = unit_status.out_supply_fault;
  // RULE_08 any standard error
  assign gen_stat[image_packer_pkg::GS_STD_ERR]    = |unit_status.std_conn_err;
  // RULE_09 all standard running
  assign gen_stat[image_packer_pkg::GS_STD_RUN]    = (&unit_status.std_conn_active)
                                                    & ~(|unit_status.std_conn_err);
  // RULE_10 any safety error
  assign gen_stat[image_packer_pkg::GS_SAF_ERR]    = |unit_status.saf_conn_err;
  // RULE_11 all safety running
  assign gen_stat[image_packer_pkg::GS_SAF_RUN]    = (&unit_status.saf_conn_active)
                                                    & ~(|unit_status.saf_conn_err);
  // RULE_12 run mode flag
  assign gen_stat[image_packer_pkg::GS_RUN_MODE]   = unit_status.run_mode;
  // RULE_13 controller health flag
  assign gen_stat[image_packer_pkg::GS_HEALTH]     = ~unit_status.error_present;
  wire logic controller_health_flag = gen_stat[image_packer_pkg::GS_HEALTH];

  // ----------------------------------------------------------------------------
  // candidate byte slots in image order
  // ----------------------------------------------------------------------------
  wire logic       newer_unit = ctrl_reg[image_packer_pkg::CTRL_NEWER_BIT];
  wire logic [7:0] sel        = select_reg[7:0];
  logic [7:0]      cand     [image_packer_pkg::CAND_N];
  logic            cand_en  [image_packer_pkg::CAND_N];
  // RULE_01 fixed status order
  assign cand[0]    = gen_stat;
  assign cand_en[0] = sel[image_packer_pkg::SEL_GEN];
  // RULE_14 older unit: low byte of the word; RULE_15 newer unit: byte 1
  assign cand[1]    = unit_status.in_terminal_ok[7:0];
  assign cand_en[1] = sel[image_packer_pkg::SEL_LIS1];
  // RULE_16 newer byte 2; RULE_14 older word travels whole on one select
  assign cand[2]    = unit_status.in_terminal_ok[15:8];
  assign cand_en[2] = newer_unit ? sel[image_packer_pkg::SEL_LIS2]
                                 : sel[image_packer_pkg::SEL_LIS1];
  assign cand[3]    = unit_status.out_terminal_ok;
  assign cand_en[3] = sel[image_packer_pkg::SEL_LOS];
  assign cand[4]    = unit_status.test_out_status;
  assign cand_en[4] = sel[image_packer_pkg::SEL_TOS];
  // RULE_03 monitors after status, inputs first
  // RULE_04 older unit never emits monitor bytes
  assign cand[5]    = unit_status.in_monitor[7:0];
  assign cand_en[5] = newer_unit & sel[image_packer_pkg::SEL_LIM1];
  assign cand[6]    = unit_status.in_monitor[15:8];
  assign cand_en[6] = newer_unit & sel[image_packer_pkg::SEL_LIM2];
  assign cand[7]    = unit_status.out_monitor;
  assign cand_en[7] = newer_unit & sel[image_packer_pkg::SEL_LOM];
  // tag slots: size code 0 bool, 1 byte, 2 word, 3 double word, low byte first
  genvar gt;
  genvar gb;
  generate
    for (gt = 0; gt < image_packer_pkg::TAG_N; gt++)
    begin : g_tag
      wire logic [1:0] size_code = tag_size_reg[2*gt +: 2];
      wire logic [2:0] nbytes    = (size_code == 2'h3) ? 3'h4 :
                                   (size_code == 2'h2) ? 3'h2 : 3'h1;
      wire logic       active    = (tag_cnt_reg[3:0] > 4'(gt));
      for (gb = 0; gb < 4; gb++)
      begin : g_byte
        assign cand[image_packer_pkg::STAT_N + 4*gt + gb]    = tag_data_reg[gt][8*gb +: 8];
        // RULE_17 multi-byte tags stay contiguous
        assign cand_en[image_packer_pkg::STAT_N + 4*gt + gb] = active & (3'(gb) < nbytes);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // compaction: every enabled slot takes the next free byte
  // ----------------------------------------------------------------------------
  logic [image_packer_pkg::IMG_BYTES*8-1:0] image_next;
  logic [image_packer_pkg::LEN_W-1:0]       len_next;
  // RULE_02 unselected status closes up
  // RULE_05 tags packed in registration order
  always_comb
  begin
    int pos;
    pos        = 0;
    image_next = '0;
    for (int k = 0; k < image_packer_pkg::CAND_N; k++)
    begin
      if (cand_en[k])
      begin
        image_next[pos*8 +: 8] = cand[k];
        pos = pos + 1;
      end
    end
    len_next = image_packer_pkg::LEN_W'(pos);
  end

  // image is rebuilt every cycle, so it lags its inputs by one clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      image_reg <= '0;
      len_reg   <= '0;
    end
    else
    begin
      image_reg <= image_next;
      len_reg   <= len_next;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------------------
  wire logic [image_packer_pkg::IRQ_W-1:0] irq_event;
  assign irq_event[image_packer_pkg::IRQ_HEALTH_FALL] = health_reg & ~controller_health_flag;
  assign irq_event[image_packer_pkg::IRQ_LEN_CHANGE]  = len_next != len_reg;
  assign irq_event[image_packer_pkg::IRQ_MODE_CHANGE] = mode_reg != unit_status.run_mode;

  // ----------------------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------------------
  wire logic       aw_take  = s_awvalid & awready_reg;
  wire logic       w_take   = s_wvalid & wready_reg;
  wire logic       have_aw  = aw_held_reg | aw_take;
  wire logic       have_w   = w_held_reg | w_take;
  wire logic       do_wr    = have_aw & have_w;
  wire logic [7:0] wr_addr  = aw_held_reg ? awaddr_reg : s_awaddr;
  wire logic [31:0] wr_data = w_held_reg ? wdata_reg : s_wdata;
  wire logic [3:0] wr_strb  = w_held_reg ? wstrb_reg : s_wstrb;
  wire logic       aw_held_next = have_aw & ~do_wr;
  wire logic       w_held_next  = have_w & ~do_wr;
  wire logic       bvalid_next  = do_wr | (bvalid_reg & ~s_bready);
  wire logic [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                                 {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  localparam logic [7:0] TAG_END = 8'(image_packer_pkg::OFF_TAG_DATA
                                      + 4 * image_packer_pkg::TAG_N);  // no alias past last tag
  wire logic wr_ctrl   = do_wr & (wr_addr == image_packer_pkg::OFF_CTRL);
  wire logic wr_select = do_wr & (wr_addr == image_packer_pkg::OFF_SELECT);
  wire logic wr_cnt    = do_wr & (wr_addr == image_packer_pkg::OFF_TAG_CNT);
  wire logic wr_size   = do_wr & (wr_addr == image_packer_pkg::OFF_TAG_SIZE);
  wire logic wr_mask   = do_wr & (wr_addr == image_packer_pkg::OFF_IRQ_MASK);
  wire logic wr_in_tag = (wr_addr >= image_packer_pkg::OFF_TAG_DATA)
                       & (wr_addr < TAG_END);
  wire logic [1:0] wr_tag_idx = wr_addr[3:2];
  // status register is read-clear, so writes to it are accepted and ignored
  wire logic wr_known  = wr_ctrl | wr_select | wr_cnt | wr_size | wr_mask
                       | (do_wr & wr_in_tag)
                       | (do_wr & (wr_addr == image_packer_pkg::OFF_IRQ_STAT));
  // handshake state; readies drop while a response waits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= image_packer_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      if (aw_take)
        awaddr_reg <= s_awaddr;
      if (w_take)
      begin
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg  <= ~w_held_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (do_wr)
        bresp_reg <= wr_known ? image_packer_pkg::RESP_OKAY : image_packer_pkg::RESP_SLVERR;
    end
  end

  // configuration registers except tag count honour byte strobes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg     <= image_packer_pkg::RST_CTRL;
      select_reg   <= image_packer_pkg::RST_SELECT;
      tag_cnt_reg  <= image_packer_pkg::RST_TAG_CNT;
      tag_size_reg <= image_packer_pkg::RST_TAG_SIZE;
      irq_mask_reg <= image_packer_pkg::RST_IRQ_MASK;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= (ctrl_reg & ~strb_mask) | (wr_data & strb_mask);
      if (wr_select)
        select_reg <= (select_reg & ~strb_mask) | (wr_data & strb_mask);
      // tag count takes the low four data bits and saturates them at the number of tag slots
      if (wr_cnt)
        tag_cnt_reg <= (wr_data[3:0] > 4'(image_packer_pkg::TAG_N))
                     ? 32'(image_packer_pkg::TAG_N) : {28'h0000000, wr_data[3:0]};
      if (wr_size)
        tag_size_reg <= (tag_size_reg & ~strb_mask) | (wr_data & strb_mask);
      if (wr_mask)
        irq_mask_reg <= (irq_mask_reg & ~strb_mask) | (wr_data & strb_mask);
    end
  end

  // tag values, one word each
  genvar gd;
  generate
    for (gd = 0; gd < image_packer_pkg::TAG_N; gd++)
    begin : g_tag_data
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          tag_data_reg[gd] <= 32'h0000_0000;
        else if (do_wr & wr_in_tag & (wr_tag_idx == 2'(gd)))
          tag_data_reg[gd] <= (tag_data_reg[gd] & ~strb_mask) | (wr_data & strb_mask);
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------------
  wire logic       ar_take     = s_arvalid & arready_reg;
  wire logic       rvalid_next = ar_take | (rvalid_reg & ~s_rready);
  wire logic [7:0] rd_addr     = s_araddr;
  wire logic       rd_in_tag   = (rd_addr >= image_packer_pkg::OFF_TAG_DATA)
                               & (rd_addr < TAG_END);
  wire logic       rd_in_img   = (rd_addr >= image_packer_pkg::OFF_IMAGE)
                               & (rd_addr < 8'(image_packer_pkg::OFF_IMAGE
                                              + 4 * image_packer_pkg::IMG_WORDS));
  wire logic [2:0] rd_img_idx  = rd_addr[4:2];
  wire logic       rd_stat     = ar_take & (rd_addr == image_packer_pkg::OFF_IRQ_STAT);
  logic [31:0]     rd_word;
  logic            rd_ok;
  // read mux; unmapped words answer zero with an error
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (rd_addr)
      image_packer_pkg::OFF_CTRL:     rd_word = ctrl_reg;
      image_packer_pkg::OFF_SELECT:   rd_word = select_reg;
      image_packer_pkg::OFF_TAG_CNT:  rd_word = tag_cnt_reg;
      image_packer_pkg::OFF_TAG_SIZE: rd_word = tag_size_reg;
      image_packer_pkg::OFF_IMG_LEN:  rd_word = 32'(len_reg);
      image_packer_pkg::OFF_GEN_STAT: rd_word = {24'h000000, gen_stat};
      image_packer_pkg::OFF_IRQ_STAT: rd_word = 32'(irq_stat_reg);
      image_packer_pkg::OFF_IRQ_MASK: rd_word = irq_mask_reg;
      default:
      begin
        if (rd_in_tag)
          rd_word = tag_data_reg[rd_addr[3:2]];
        else if (rd_in_img)
          rd_word = image_reg[rd_img_idx*32 +: 32];
        else
          rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= image_packer_pkg::RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? image_packer_pkg::RESP_OKAY : image_packer_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sticky status, read-clear; a new event in the clearing cycle survives
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= '0;
      health_reg   <= 1'b1;
      mode_reg     <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_event;
      health_reg   <= controller_health_flag;
      mode_reg     <= unit_status.run_mode;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg[image_packer_pkg::IRQ_W-1:0]);
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign s_awready  = awready_reg;
  assign s_wready   = wready_reg;
  assign s_bvalid   = bvalid_reg;
  assign s_bresp    = bresp_reg;
  assign s_arready  = arready_reg;
  assign s_rvalid   = rvalid_reg;
  assign s_rdata    = rdata_reg;
  assign s_rresp    = rresp_reg;
  assign image_data = image_reg;
  assign image_len  = len_reg;
  assign irq        = irq_reg;

endmodule : image_packer

// File: image_packer_monitor.sv
`timescale 1ns/1ps
module image_packer_monitor
(
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic [7:0]                     s_awaddr,
  input wire logic                           s_awvalid,
  input wire logic                           s_awready,
  input wire logic [31:0]                    s_wdata,
  input wire logic                           s_wvalid,
  input wire logic                           s_wready,
  input wire image_packer_pkg::unit_status_t unit_status,
  input wire logic [255:0]                   image_data
);
  logic gen_reg;
  logic gen_q_reg;
  // byte 0 is general status only once select has stood for a cycle
  wire image_packer_pkg::unit_status_t u = unit_status;
  wire on = gen_reg & gen_q_reg;
  wire sel_wr = s_awvalid & s_awready & s_wvalid & s_wready &
                (s_awaddr == image_packer_pkg::OFF_SELECT);
  // select bit 0 mirror; misses writes whose address and data part company
  always_ff @(posedge aclk)
  begin
    gen_q_reg <= aresetn & gen_reg;
    if (!aresetn || sel_wr) gen_reg <= aresetn & s_wdata[0];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_in_supply: assert property (on |->
    image_data[0] == $past(u.in_supply_fault)) else $error("bit 0 wrong");
  chk_out_supply: assert property (on |->
    image_data[1] == $past(u.out_supply_fault)) else $error("bit 1 wrong");
  chk_std_err: assert property (on |->
    image_data[2] == $past(|u.std_conn_err)) else $error("bit 2 wrong");
  chk_std_run: assert property (on |->
    image_data[3] == $past(&u.std_conn_active && !u.std_conn_err)) else $error("bit 3 wrong");
  chk_saf_err: assert property (on |->
    image_data[4] == $past(|u.saf_conn_err)) else $error("bit 4 wrong");
  chk_saf_run: assert property (on |->
    image_data[5] == $past(&u.saf_conn_active && !u.saf_conn_err)) else $error("bit 5 wrong");
  chk_run_mode: assert property (on && $past(on) |->
    image_data[6] == $past(u.run_mode)) else $error("bit 6 wrong");
  chk_health_flag: assert property (on |->
    image_data[7] != $past(u.error_present)) else $error("bit 7 wrong");
endmodule : image_packer_monitor
bind image_packer image_packer_monitor mon (.*);

// File: image_packer_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and carriers for the remote input image packer
// ----------------------------------------------------------------------------
package image_packer_pkg;

  // connection counts behind the general status summary bits
  localparam int CONN_N     = 4;
  localparam int TAG_N      = 4;
  localparam int STAT_N     = 8;   // fixed status and monitor byte slots
  localparam int CAND_N     = STAT_N + 4 * TAG_N;
  localparam int IMG_BYTES  = 32;
  localparam int IMG_WORDS  = IMG_BYTES / 4;
  localparam int LEN_W      = 6;

  // ----------------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SELECT   = 8'h04;
  localparam logic [7:0] OFF_TAG_CNT  = 8'h08;
  localparam logic [7:0] OFF_TAG_SIZE = 8'h0c;
  localparam logic [7:0] OFF_IMG_LEN  = 8'h10;
  localparam logic [7:0] OFF_GEN_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFF_TAG_DATA = 8'h20;  // one word per tag
  localparam logic [7:0] OFF_IMAGE    = 8'h40;  // image words, read only

  // reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0001;
  localparam logic [31:0] RST_SELECT   = 32'h0000_0000;
  localparam logic [31:0] RST_TAG_CNT  = 32'h0000_0000;
  localparam logic [31:0] RST_TAG_SIZE = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

  // control and select field positions
  localparam int CTRL_NEWER_BIT = 0;
  localparam int SEL_GEN        = 0;
  localparam int SEL_LIS1       = 1;
  localparam int SEL_LIS2       = 2;
  localparam int SEL_LOS        = 3;
  localparam int SEL_TOS        = 4;
  localparam int SEL_LIM1       = 5;
  localparam int SEL_LIM2       = 6;
  localparam int SEL_LOM        = 7;

  // interrupt event positions
  localparam int IRQ_HEALTH_FALL = 0;
  localparam int IRQ_LEN_CHANGE  = 1;
  localparam int IRQ_MODE_CHANGE = 2;
  localparam int IRQ_W           = 3;

  // general status bit positions
  localparam int GS_IN_SUPPLY  = 0;
  localparam int GS_OUT_SUPPLY = 1;
  localparam int GS_STD_ERR    = 2;
  localparam int GS_STD_RUN    = 3;
  localparam int GS_SAF_ERR    = 4;
  localparam int GS_SAF_RUN    = 5;
  localparam int GS_RUN_MODE   = 6;
  localparam int GS_HEALTH     = 7;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // live controller state sampled into the image
  typedef struct packed {
    logic              in_supply_fault;
    logic              out_supply_fault;
    logic [CONN_N-1:0] std_conn_err;
    logic [CONN_N-1:0] std_conn_active;
    logic [CONN_N-1:0] saf_conn_err;
    logic [CONN_N-1:0] saf_conn_active;
    logic              run_mode;
    logic              error_present;
    logic [15:0]       in_terminal_ok;
    logic [7:0]        out_terminal_ok;
    logic [7:0]        test_out_status;
    logic [15:0]       in_monitor;
    logic [7:0]        out_monitor;
  } unit_status_t;

endpackage : image_packer_pkg

// File: image_reader.sv
`timescale 1ns/1ps
module image_reader
(
  input  wire logic         aclk,
  input  wire logic [255:0] image_data,
  input  wire logic [5:0]   image_len,
  output logic      [255:0] seen_img,
  output logic      [5:0]   seen_len
);
  // master polls the slave input area once a cycle, one cycle behind
  always_ff @(posedge aclk) {seen_img, seen_len} <= {image_data, image_len};
endmodule : image_reader

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic ctrl; logic [7:0] sel; logic [5:0] len; logic [127:0] img;} row_t;
  localparam image_packer_pkg::unit_status_t US1 =
    '{1'b1, 1'b0, 4'h0, 4'hf, 4'h2, 4'hf, 1'b1, 1'b0, 16'hb2c1, 8'hd3, 8'he4, 16'h9687, 8'h78};
  localparam image_packer_pkg::unit_status_t US2 =
    '{1'b0, 1'b1, 4'h1, 4'hf, 4'h0, 4'hf, 1'b0, 1'b1, 16'hb2c1, 8'hd3, 8'he4, 16'h9687, 8'h78};
  // tags 11, 2233 and 44556677 close up behind whatever items are selected
  localparam row_t ROWS [5] = '{'{1'b1, 8'h1f, 6'd12, 128'h44556677223311e4d3b2c1d9},
    '{1'b1, 8'h0e, 6'd10, 128'h44556677223311d3b2c1},
    '{1'b1, 8'ha0, 6'd9, 128'h445566772233117887},
    '{1'b1, 8'hff, 6'd15, 128'h44556677223311789687e4d3b2c1d9},
    '{1'b0, 8'hff, 6'd12, 128'h44556677223311e4d3b2c1d9}};
  logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, d;
  logic [1:0] s_bresp, s_rresp, r;
  logic [255:0] image_data, seen_img;
  logic [5:0] image_len, seen_len;
  int fail_count = 0, total_checks = 0;
  image_packer_pkg::unit_status_t unit_status = US1;
  image_packer dut (.s_wstrb(4'hf), .*);
  image_reader master (.*);
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle
  // ready is looked at on the negedge so the release after the edge never races it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, v, 3'b111};
    do
    begin
      @(negedge aclk);
      {ta, tw, tb, r} = {s_awvalid & s_awready, s_wvalid & s_wready, s_bvalid, s_bresp};
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end while (!tb);
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    @(posedge aclk);
    {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
    do
    begin
      @(negedge aclk);
      {ta, tv, d, r} = {s_arready, s_rvalid, s_rdata, s_rresp};
      @(posedge aclk);
      if (ta) s_arvalid <= 1'b0;
    end while (!tv);
    s_rready <= 1'b0;
  endtask : rd
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial forever #5 aclk = ~aclk;
  // watchdog at 10000 cycles, far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #100000;
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("reset length", 0, image_len);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i));
      chk("reset register", i == 0, d);
    end
    wr(image_packer_pkg::OFF_TAG_DATA, 32'h11);
    wr(image_packer_pkg::OFF_TAG_DATA + 8'h04, 32'h2233);
    wr(image_packer_pkg::OFF_TAG_DATA + 8'h08, 32'h44556677);
    wr(image_packer_pkg::OFF_TAG_SIZE, 32'h39);
    wr(image_packer_pkg::OFF_TAG_CNT, 32'h3);
    foreach (ROWS[i])
    begin
      wr(image_packer_pkg::OFF_CTRL, {31'h0, ROWS[i].ctrl});
      wr(image_packer_pkg::OFF_SELECT, {24'h0, ROWS[i].sel});
      settle();
      chk("image", ROWS[i].img, seen_img[127:0]);
      chk("length", ROWS[i].len, seen_len);
    end
    wr(image_packer_pkg::OFF_SELECT, 32'h1);
    settle();
    rd(image_packer_pkg::OFF_IRQ_STAT);
    chk("general status", 8'hd9, seen_img[7:0]);
    @(posedge aclk);
    unit_status <= US2;
    settle();
    chk("general status", 8'h26, seen_img[7:0]);
    chk("masked irq", 0, irq);
    wr(image_packer_pkg::OFF_IRQ_MASK, 32'h4);
    settle();
    chk("irq raised", 1, irq);
    rd(image_packer_pkg::OFF_IRQ_STAT);
    chk("irq status", 5, d);
    settle();
    chk("irq cleared", 0, irq);
    rd(image_packer_pkg::OFF_IMAGE);
    chk("image word", 32'h22331126, d);
    wr(image_packer_pkg::OFF_TAG_DATA + 8'h0c, 32'hccbbaa);
    wr(image_packer_pkg::OFF_TAG_CNT, 32'h9);
    settle();
    chk("bool tag", 70'h9aa44556677223311, {seen_len, seen_img[71:8]});
    rd(8'h30);
    chk("past last tag", 34'h2, {d, r});
    wr(8'hfc, 32'h1);
    chk("unmapped write", 2'b10, r);
    rd(8'hfc);
    chk("unmapped read", 34'h2, {d, r});
    test_done();
  end
endmodule : tb_top
